// ===== verilog/mux_intr_map.svh
// register offsets, field positions, reset values and condition codes
`ifndef MUX_INTR_MAP_SVH
`define MUX_INTR_MAP_SVH
`define OFF_RX_CHAR      12'h000
`define OFF_TX_STATUS    12'h004
`define OFF_SEC_SELECT   12'h008
`define OFF_LINE_CTRL    12'h00c
`define OFF_LINE_STATE   12'h010
`define OFF_INT_STATUS   12'h014
`define OFF_INT_MASK     12'h018
`define RX_CODE_LSB      12
`define RX_LINE_LSB      8
`define TX_CODE_LSB      8
`define LC_PENDING_BIT   15
`define INT_RX_BIT       0
`define INT_TX_BIT       1
`define RST_WORD         32'h0000_0000
`define RX_PARITY        4'h1
`define RX_OVERRUN       4'h2
`define RX_FRAMING       4'h3
`define RX_UNDEF_LO      4'h9
`define RX_UNDEF_HI      4'hb
`define RX_STORE_MISSING 4'hc
`define RX_CTRL_MISSING  4'hd
`define RX_STORE_PARITY  4'he
`define RX_CTRL_PARITY   4'hf
`define TX_PRIM_MISSING  4'h0
`define TX_PRIM_ZERO     4'h1
`define TX_ALT_MISSING   4'h2
`define TX_ALT_ZERO      4'h3
`define TX_CTRL_ERROR    4'h8
`endif

// ===== verilog/mux_intr_pkg.sv
// types shared by the interrupt condition encoder
package mux_intr_pkg;
    typedef enum logic [2:0] {
        TX_PRIM_MISSING_EV,
        TX_PRIM_ZERO_EV,
        TX_ALT_MISSING_EV,
        TX_ALT_ZERO_EV,
        TX_CTRL_ERROR_EV
    } tx_kind_type;

    typedef struct packed {
        logic       valid;
        logic       async_line;
        logic [3:0] line;
        logic [7:0] char_data;
        logic [3:0] base_code;
        logic       parity_err;
        logic       overrun_err;
        logic       framing_err;
        logic       store_missing;
        logic       ctrl_missing;
        logic       store_parity;
        logic       ctrl_parity;
    } rx_event_type;

    typedef struct packed {
        logic        valid;
        logic [3:0]  line;
        tx_kind_type kind;
        logic        ctrl_parity;
    } tx_event_type;

    typedef struct packed {
        logic        valid;
        logic [3:0]  line;
        logic [14:0] data;
    } lc_load_type;
endpackage

// ===== verilog/mux_interrupt_condition_encoder.sv
// interrupt condition encoder with apb register slave
//
// Summary of operation
// - rx word: char, line, code
// - async codes parity 1, overrun 2, framing 3
// - store missing-memory timeout gives 1100
// - control fetch timeout gives 1101
// - store parity error gives 1110
// - control fetch parity error gives 1111
// - any overrun combination reports overrun
// - framing plus parity reports framing
// - priority only on async lines
// - tx code in bits eight to eleven
// - primary missing 0000, alternate missing 0010
// - primary byte count zero gives 0001
// - alternate byte count zero gives 0011
// - control fetch memory error gives 1000
// - line state records which error
// - select low bits pick line control storage
// - bit 15 set while load pending
`timescale 1ns/100ps
`include "mux_intr_map.svh"

module mux_interrupt_condition_encoder
    import mux_intr_pkg::*;
#(
    parameter int LINES = 16
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire rx_event_type rx_event,
    input  wire tx_event_type tx_event,
    output lc_load_type       lc_load,
    input  wire logic         lc_done,
    output logic              irq
);
    // ------------------------------------------------------------
    // receive condition encoding
    // ------------------------------------------------------------
    logic       rx_mem_err;
    logic [3:0] rx_line_code;
    logic [3:0] rx_code;
    logic       rx_undef;
    logic       rx_take;

    assign rx_mem_err = rx_event.store_missing | rx_event.ctrl_missing
                      | rx_event.store_parity  | rx_event.ctrl_parity;
    // async errors collapse to one code; sync codes pass untouched
    assign rx_line_code = !rx_event.async_line ? rx_event.base_code
                        : rx_event.overrun_err ? `RX_OVERRUN
                        : rx_event.framing_err ? `RX_FRAMING
                        : rx_event.parity_err  ? `RX_PARITY
                        : rx_event.base_code;
    // fetch errors first: the control byte is read before the store
    assign rx_code = rx_event.ctrl_parity   ? `RX_CTRL_PARITY
                   : rx_event.ctrl_missing  ? `RX_CTRL_MISSING
                   : rx_event.store_parity  ? `RX_STORE_PARITY
                   : rx_event.store_missing ? `RX_STORE_MISSING
                   : rx_line_code;
    assign rx_undef = rx_code >= `RX_UNDEF_LO && rx_code <= `RX_UNDEF_HI;
    // an event that would carry an undefined code is dropped
    assign rx_take = rx_event.valid && !rx_undef;

    // ------------------------------------------------------------
    // transmit condition encoding
    // ------------------------------------------------------------
    logic [3:0] tx_code;
    logic       tx_known;
    logic       tx_take;

    always_comb
    begin
        tx_known = 1'b1;
        case (tx_event.kind)
            TX_PRIM_MISSING_EV: tx_code = `TX_PRIM_MISSING;
            TX_PRIM_ZERO_EV:    tx_code = `TX_PRIM_ZERO;
            TX_ALT_MISSING_EV:  tx_code = `TX_ALT_MISSING;
            TX_ALT_ZERO_EV:     tx_code = `TX_ALT_ZERO;
            TX_CTRL_ERROR_EV:   tx_code = `TX_CTRL_ERROR;
            default:
            begin
                tx_code  = `TX_PRIM_MISSING;
                tx_known = 1'b0;
            end
        endcase
    end
    assign tx_take = tx_event.valid && tx_known;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        irq_q;
    logic [15:0] ric_q;
    logic [15:0] tx_status_q;
    logic [15:0] sec_select_q;
    logic [1:0]  int_status_q;
    logic [1:0]  int_status_d;
    logic [1:0]  int_mask_q;
    logic        lc_pending_q;
    lc_load_type lc_load_q;
    logic [14:0] lc_store_q [LINES];
    logic [1:0]  line_state_q [LINES];

    logic        setup;
    logic        access;
    logic        wr_en;
    logic        hit_ric;
    logic        hit_tx;
    logic        hit_sel;
    logic        hit_lc;
    logic        hit_ls;
    logic        hit_ist;
    logic        hit_msk;
    logic        mapped;
    logic        lc_write;
    logic        ist_read;
    logic [3:0]  sel_line;
    logic [31:0] rd_word;
    logic [1:0]  int_set;

    assign setup   = psel && !penable && !pready_q;
    assign access  = psel && penable && pready_q;
    assign wr_en   = access && pwrite && !pslverr_q;
    assign hit_ric = paddr == `OFF_RX_CHAR;
    assign hit_tx  = paddr == `OFF_TX_STATUS;
    assign hit_sel = paddr == `OFF_SEC_SELECT;
    assign hit_lc  = paddr == `OFF_LINE_CTRL;
    assign hit_ls  = paddr == `OFF_LINE_STATE;
    assign hit_ist = paddr == `OFF_INT_STATUS;
    assign hit_msk = paddr == `OFF_INT_MASK;
    assign mapped  = hit_ric | hit_tx | hit_sel | hit_lc | hit_ls
                   | hit_ist | hit_msk;
    assign sel_line = sec_select_q[3:0];
    // a load while one is outstanding is ignored, not queued
    assign lc_write = wr_en && hit_lc && !lc_pending_q;
    assign ist_read = access && !pwrite && hit_ist;

    assign rd_word =
        hit_ric ? {16'h0000, ric_q}
      : hit_tx  ? {16'h0000, tx_status_q}
      : hit_sel ? {16'h0000, sec_select_q}
      : hit_lc  ? {16'h0000, lc_pending_q, lc_store_q[sel_line]}
      : hit_ls  ? {30'h0000_0000, line_state_q[sel_line]}
      : hit_ist ? {30'h0000_0000, int_status_q}
      : hit_msk ? {30'h0000_0000, int_mask_q}
      : `RST_WORD;

    assign int_set = {tx_take, rx_take};
    // a read clears only the bits it returned, so an event landing
    // between setup and access is kept; a new event beats the clear
    assign int_status_d = (int_status_q & ~(prdata_q[1:0] & {2{ist_read}}))
                        | int_set;

    // ------------------------------------------------------------
    // bus answer and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q     <= 1'b0;
            prdata_q     <= `RST_WORD;
            pslverr_q    <= 1'b0;
            int_status_q <= 2'b00;
            int_mask_q   <= 2'b00;
            irq_q        <= 1'b0;
        end
        else
        begin
            pready_q     <= setup;
            prdata_q     <= setup && !pwrite ? rd_word : `RST_WORD;
            pslverr_q    <= setup && !mapped;
            int_status_q <= int_status_d;
            if (wr_en && hit_msk)
                int_mask_q <= pwdata[1:0];
            irq_q        <= |(int_status_d & int_mask_q);
        end
    end

    // ------------------------------------------------------------
    // condition registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ric_q       <= 16'h0000;
            tx_status_q <= 16'h0000;
        end
        else
        begin
            if (rx_take)
                ric_q <= {rx_code, rx_event.line, rx_event.char_data};
            if (tx_take)
                tx_status_q <= {4'h0, tx_code, 4'h0, tx_event.line};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_state_q <= '{default: 2'b00};
        else if (tx_take && tx_event.kind == TX_CTRL_ERROR_EV)
            line_state_q[tx_event.line] <=
                {tx_event.ctrl_parity, !tx_event.ctrl_parity};
    end

    // ------------------------------------------------------------
    // secondary select and line control load
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_select_q <= 16'h0000;
            lc_pending_q <= 1'b0;
            lc_load_q    <= '0;
            lc_store_q   <= '{default: 15'h0000};
        end
        else
        begin
            // the select is taken as written, even while a load is pending;
            // the pending load keeps the line latched when it was written
            if (wr_en && hit_sel)
                sec_select_q <= pwdata[15:0];
            if (lc_write)
            begin
                lc_store_q[sel_line] <= pwdata[14:0];
                lc_load_q.valid      <= 1'b1;
                lc_load_q.line       <= sel_line;
                lc_load_q.data       <= pwdata[14:0];
                lc_pending_q         <= 1'b1;
            end
            else
            begin
                lc_load_q.valid <= 1'b0;
                if (lc_done)
                    lc_pending_q <= 1'b0;
            end
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign lc_load = lc_load_q;
    assign irq     = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rx_clean;
    assign rx_clean = rx_take && !rx_mem_err && rx_event.async_line;

    property p_rx_layout;
        rx_take |=> ric_q[7:0] == $past(rx_event.char_data)
            && ric_q[11:8] == $past(rx_event.line);
    endproperty
    a_rx_layout: assert property (p_rx_layout)
        else $error("rx char or line misplaced");

    property p_rx_overrun;
        rx_clean && rx_event.overrun_err |=> ric_q[15:12] == 4'h2;
    endproperty
    a_rx_overrun: assert property (p_rx_overrun)
        else $error("overrun not reported as overrun");

    property p_rx_framing;
        rx_clean && !rx_event.overrun_err && rx_event.framing_err
            |=> ric_q[15:12] == 4'h3;
    endproperty
    a_rx_framing: assert property (p_rx_framing)
        else $error("framing not reported as framing");

    property p_rx_sync;
        rx_take && !rx_mem_err && !rx_event.async_line
            |=> ric_q[15:12] == $past(rx_event.base_code);
    endproperty
    a_rx_sync: assert property (p_rx_sync)
        else $error("sync code altered");

    property p_rx_store_missing;
        rx_take && rx_event.store_missing && !rx_event.ctrl_missing
            && !rx_event.ctrl_parity && !rx_event.store_parity
            |=> ric_q[15:12] == 4'hc;
    endproperty
    a_rx_store_missing: assert property (p_rx_store_missing)
        else $error("store timeout code wrong");

    property p_rx_ctrl_parity;
        rx_take && rx_event.ctrl_parity |=> ric_q[15:12] == 4'hf;
    endproperty
    a_rx_ctrl_parity: assert property (p_rx_ctrl_parity)
        else $error("control parity code wrong");

    property p_rx_defined;
        !(ric_q[15:12] inside {4'h9, 4'ha, 4'hb});
    endproperty
    a_rx_defined: assert property (p_rx_defined)
        else $error("undefined receive code produced");

    property p_tx_ctrl;
        tx_take && tx_event.kind == TX_CTRL_ERROR_EV
            |=> tx_status_q[11:8] == 4'h8
            && line_state_q[$past(tx_event.line)][1]
               == $past(tx_event.ctrl_parity);
    endproperty
    a_tx_ctrl: assert property (p_tx_ctrl)
        else $error("control fetch error not recorded");

    property p_tx_alt_zero;
        tx_take && tx_event.kind == TX_ALT_ZERO_EV
            |=> tx_status_q[11:8] == 4'h3;
    endproperty
    a_tx_alt_zero: assert property (p_tx_alt_zero)
        else $error("alternate zero count code wrong");

    property p_lc_pending;
        lc_write |=> lc_pending_q && lc_load_q.valid ##1 !lc_load_q.valid
            && (lc_pending_q || $past(lc_done));
    endproperty
    a_lc_pending: assert property (p_lc_pending)
        else $error("pending bit or load pulse wrong");

    property p_lc_clear;
        lc_pending_q && lc_done && !lc_write |=> !lc_pending_q;
    endproperty
    a_lc_clear: assert property (p_lc_clear)
        else $error("pending bit not cleared on done");

    c_overrun_mix: cover property (rx_clean && rx_event.overrun_err
        && rx_event.parity_err);
    c_lc_cycle: cover property (lc_write ##[1:20] lc_done);
    c_irq: cover property ($rose(irq_q) ##[1:20] ist_read);
endmodule

// ===== tb/line_card_model.sv
// line card stand-in: takes line control loads and reports completion
`timescale 1ns/100ps

module line_card_model
    import mux_intr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire lc_load_type lc_load,
    input  wire logic        slow,
    output logic             lc_done,
    output logic [3:0]       seen_line,
    output logic [14:0]      seen_data
);
    logic [4:0] cnt_q;

    // ----------------------------------------
    // completion after 1 or 20 cycles
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q     <= 5'h00;
            lc_done   <= 1'b0;
            seen_line <= 4'h0;
            seen_data <= 15'h0000;
        end
        else
        begin
            lc_done <= (cnt_q == 5'h01);
            if (lc_load.valid)
            begin
                cnt_q     <= slow ? 5'h14 : 5'h01;
                seen_line <= lc_load.line;
                seen_data <= lc_load.data;
            end
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
        end
    end
endmodule

// ===== tb/mux_interrupt_condition_encoder_test.sv
// self-checking bench for the interrupt condition encoder
`timescale 1ns/100ps
`include "mux_intr_map.svh"

module mux_interrupt_condition_encoder_test
    import mux_intr_pkg::*;
();
    logic         pclk = 1'b0;
    logic         presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic         lc_done, slow;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rx_last, tx_last, rd;
    logic [1:0]   msk;
    logic [3:0]   seen_line;
    logic [14:0]  seen_data;
    rx_event_type rx_event;
    tx_event_type tx_event;
    lc_load_type  lc_load;
    int           error_cnt, samples_checked, nxt;

    always #20 pclk = ~pclk;

    mux_interrupt_condition_encoder mux_interrupt_condition_encoder_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .rx_event(rx_event),
        .tx_event(tx_event), .lc_load(lc_load), .lc_done(lc_done),
        .irq(irq));

    line_card_model line_card_model_i (
        .pclk(pclk), .presetn(presetn), .lc_load(lc_load), .slow(slow),
        .lc_done(lc_done), .seen_line(seen_line), .seen_data(seen_data));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checked %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a hung access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic er;
        apb(1'b1, a, d, er);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic er;
        apb(1'b0, a, 32'h0, er);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0);
    endtask

    // pending must read clear before the select is touched
    task automatic sel(input logic [3:0] l);
        logic er;
        apb(1'b0, `OFF_LINE_CTRL, 32'h0, er);
        chk({31'h0, rd[15]}, 32'h0);
        wr(`OFF_SEC_SELECT, {28'h0, l});
    endtask

    task automatic wait_lc();
        logic er;
        int   n;
        n = 0;
        do
        begin
            apb(1'b0, `OFF_LINE_CTRL, 32'h0, er);
            n++;
        end
        while (rd[15] !== 1'b0 && n < 40);
        chk({31'h0, rd[15]}, 32'h0);
    endtask

    // event, irq, status clear-on-read, then the report register
    task automatic ev_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic [1:0] st);
        @(posedge pclk);
        rx_event <= '0;
        tx_event <= '0;
        @(posedge pclk);
        chk({31'h0, irq}, {31'h0, |(st & msk)});
        rdchk(`OFF_INT_STATUS, {30'h0, st});
        rdchk(`OFF_INT_STATUS, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(a, exp);
    endtask

    task automatic rx_case(input logic a, input logic [3:0] base,
                           input logic [6:0] f, input logic [3:0] code);
        rx_event_type ev;
        logic         drop;
        ev = '0;
        ev.valid = 1'b1;
        ev.async_line = a;
        ev.line = nxt[3:0];
        ev.char_data = {4'ha, ~nxt[3:0]};
        ev.base_code = base;
        {ev.parity_err, ev.overrun_err, ev.framing_err, ev.store_missing,
         ev.ctrl_missing, ev.store_parity, ev.ctrl_parity} = f;
        nxt++;
        drop = (code >= `RX_UNDEF_LO) && (code <= `RX_UNDEF_HI);
        if (!drop)
            rx_last = {16'h0, code, ev.line, ev.char_data};
        @(posedge pclk);
        rx_event <= ev;
        ev_chk(`OFF_RX_CHAR, rx_last, {1'b0, !drop});
    endtask

    task automatic tx_case(input logic [2:0] k, input logic p,
                           input logic [3:0] l, input logic [3:0] code);
        tx_event_type ev;
        ev.valid = 1'b1;
        ev.line = l;
        ev.kind = tx_kind_type'(k);
        ev.ctrl_parity = p;
        if (k < 3'h5)
            tx_last = {20'h0, code, 4'h0, l};
        @(posedge pclk);
        tx_event <= ev;
        ev_chk(`OFF_TX_STATUS, tx_last, {k < 3'h5, 1'b0});
    endtask

    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("[FAIL] %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        logic er;
        {presetn, psel, penable, pwrite, slow} = 5'h0;
        {paddr, pwdata, rx_last, tx_last, msk} = '0;
        rx_event = '0;
        tx_event = '0;
        error_cnt = 0;
        samples_checked = 0;
        nxt = 1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`OFF_RX_CHAR, `RST_WORD);
        rdchk(`OFF_TX_STATUS, `RST_WORD);
        rdchk(`OFF_INT_MASK, `RST_WORD);
        apb(1'b1, 12'h01c, 32'hffff_ffff, er);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h01c, 32'h0, er);
        chk({er, rd[30:0]}, 32'h8000_0000);
        msk = 2'h3;
        wr(`OFF_INT_MASK, 32'h3);
        rx_case(1'b1, 4'h0, 7'b1000000, `RX_PARITY);
        rx_case(1'b1, 4'h0, 7'b0100000, `RX_OVERRUN);
        rx_case(1'b1, 4'h0, 7'b0010000, `RX_FRAMING);
        rx_case(1'b1, 4'h0, 7'b1110000, `RX_OVERRUN);
        rx_case(1'b1, 4'h0, 7'b1100000, `RX_OVERRUN);
        rx_case(1'b1, 4'h0, 7'b1010000, `RX_FRAMING);
        rx_case(1'b0, 4'h5, 7'b1110000, 4'h5);
        rx_case(1'b1, 4'h0, 7'b0001000, `RX_STORE_MISSING);
        rx_case(1'b1, 4'h0, 7'b0000100, `RX_CTRL_MISSING);
        rx_case(1'b0, 4'h0, 7'b0000010, `RX_STORE_PARITY);
        rx_case(1'b1, 4'h0, 7'b0000001, `RX_CTRL_PARITY);
        rx_case(1'b0, 4'ha, 7'b0000000, 4'ha);
        tx_case(3'h0, 1'b0, 4'h1, `TX_PRIM_MISSING);
        tx_case(3'h1, 1'b0, 4'h2, `TX_PRIM_ZERO);
        tx_case(3'h2, 1'b0, 4'h3, `TX_ALT_MISSING);
        tx_case(3'h3, 1'b0, 4'h4, `TX_ALT_ZERO);
        tx_case(3'h4, 1'b1, 4'h6, `TX_CTRL_ERROR);
        tx_case(3'h4, 1'b0, 4'h7, `TX_CTRL_ERROR);
        tx_case(3'h6, 1'b0, 4'h9, 4'h0);
        sel(4'h6);
        rdchk(`OFF_LINE_STATE, 32'h2);
        sel(4'h7);
        rdchk(`OFF_LINE_STATE, 32'h1);
        msk = 2'h1;
        wr(`OFF_INT_MASK, 32'h1);
        tx_case(3'h1, 1'b0, 4'h5, `TX_PRIM_ZERO);
        slow <= 1'b1;
        sel(4'h3);
        wr(`OFF_LINE_CTRL, 32'h0000_1234);
        rdchk(`OFF_LINE_CTRL, 32'h0000_9234);
        wr(`OFF_LINE_CTRL, 32'h0000_0555);
        chk({17'h0, seen_line, 11'h0}, {17'h0, 4'h3, 11'h0});
        wait_lc();
        rdchk(`OFF_LINE_CTRL, 32'h0000_1234);
        chk({17'h0, seen_data}, 32'h0000_1234);
        slow <= 1'b0;
        sel(4'h4);
        wr(`OFF_LINE_CTRL, 32'h0000_0abc);
        wait_lc();
        chk({28'h0, seen_line}, 32'h4);
        rdchk(`OFF_LINE_CTRL, 32'h0000_0abc);
        sel(4'h3);
        rdchk(`OFF_LINE_CTRL, 32'h0000_1234);
        rdchk(`OFF_SEC_SELECT, 32'h0000_0003);
        close_out();
    end
endmodule
